// File: common/aenc_defines.svh
// constants for the absolute encoder readout block
`ifndef AENC_DEFINES_SVH
`define AENC_DEFINES_SVH

// position word layout
`define AENC_POS_BITS       17
`define AENC_TRACK_BITS     13
`define AENC_FINE_BITS      4
`define AENC_QUAD_CPR       2048

// serial readout frame: one trailing low bit, then a new frame if select stays low
`define AENC_FRAME_BITS     5'd17
`define AENC_FRAME_WRAP     5'd18

// configuration register map and keys
`define AENC_REG_MODE       6'h10
`define AENC_REG_UNLOCK     6'h11
`define AENC_REG_ACCESS     6'h1b
`define AENC_MODE_RESET     8'h01
`define AENC_MODE_ALIGN     8'h11
`define AENC_KEY_UNLOCK     8'hab
`define AENC_KEY_ACCESS     8'heb
`define AENC_CMD_WRITE      2'b01
`define AENC_CMD_READ       2'b10

// configuration port framing
`define AENC_SPI_BITS       5'd16
`define AENC_SPI_DATA_START 5'd8
`define AENC_SYS_CLK_MHZ    40
`define AENC_SPI_IDLE_NS    5000
`define AENC_SPI_IDLE_CYC   ((`AENC_SPI_IDLE_NS * `AENC_SYS_CLK_MHZ) / 1000)

`endif

// File: common/aenc_pkg.sv
// types shared by the absolute encoder readout block
`default_nettype none
package aenc_pkg;
  // configuration port sequencer, gray coded along idle -> shift -> exec
  typedef enum logic [1:0] {
    AENC_SPI_IDLE  = 2'b00,
    AENC_SPI_SHIFT = 2'b01,
    AENC_SPI_EXEC  = 2'b11
  } aenc_spi_state_t;
endpackage
`default_nettype wire

// File: src/aenc_pair_buf.sv
// small valid/ready buffer between the position sampler and the link handshake
`default_nettype none
module aenc_pair_buf #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // draining side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage, no reset needed since count guards reads
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  no_overflow_a: assert property (@(posedge clk) disable iff (rst)
    cnt_q <= (AW+1)'(DEPTH)) else $error("buffer count above depth");
endmodule
`default_nettype wire

// File: src/aenc_readout.sv
// absolute encoder digital side: position, serial readout, config port, alignment
//
// Overview of operation
// - position is 13 track bits plus 4 fine bits
// - readout shifts top position bit first
// - invert input high makes position count down
// - readout clocks shift data only while select low
// - zero preset low captures new zero reference
// - access key write, then unlock key write, unlocks mode register
// - alignment pattern after unlock enters alignment
// - default pattern write leaves alignment mode
// - alignment routes locate sensor to test output
// - alignment mode drives tilt strobes out
// - fault high when LED control out of range
// - fault also for heat and low light
// - A/B quadrature from sine and cosine signs
`include "aenc_defines.svh"
`default_nettype none
module aenc_readout #(
  parameter int POS_BITS  = `AENC_POS_BITS,
  parameter int BUF_DEPTH = 2,
  parameter int SPI_IDLE  = `AENC_SPI_IDLE_CYC
) (
  // system clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  // serial readout link
  input  wire logic                         readout_clk,
  input  wire logic                         readout_select_n,
  output logic                              pos_data_out,
  // optical front end
  input  wire logic [`AENC_TRACK_BITS-1:0]  track_bits,
  input  wire logic [`AENC_FINE_BITS-1:0]   fine_bits,
  input  wire logic                         sine_sign,
  input  wire logic                         cosine_sign,
  input  wire logic                         radial_locate_sensor,
  input  wire logic                         tilt_detect,
  // fault sources
  input  wire logic                         led_range_err,
  input  wire logic                         temp_over_limit,
  input  wire logic                         light_low,
  // control pins
  input  wire logic                         zero_preset_n,
  input  wire logic                         count_direction_invert,
  // configuration port
  input  wire logic                         spi_clk,
  input  wire logic                         spi_si,
  output logic                              spi_so,
  // status and alignment outputs
  output logic                              fault_flag_out,
  output logic                              locate_test_out,
  output logic                              tilt_out,
  output logic                              quad_channel_a,
  output logic                              quad_channel_b
);
  localparam int NSYNC = `AENC_TRACK_BITS + `AENC_FINE_BITS + 11;
  // reset levels: only the zero preset idles high; config clock idles low
  localparam logic [NSYNC-1:0] SYNC_INIT = NSYNC'(28'h0000400);

  // ---------------- input synchronisers ----------------
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;

  assign pin_raw = {track_bits, fine_bits, zero_preset_n, count_direction_invert,
                    spi_clk, spi_si, radial_locate_sensor, tilt_detect,
                    led_range_err, temp_over_limit, light_low, sine_sign, cosine_sign};

  // two flops per pin, the first read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          sync1_q[gi] <= SYNC_INIT[gi];
          sync2_q[gi] <= SYNC_INIT[gi];
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  logic [POS_BITS-1:0] coarse_fine_s;
  logic zero_s, inv_s, sck_s, si_s, loc_s, tilt_s, ledr_s, temp_s, lowl_s, sin_s, cos_s;
  assign {coarse_fine_s, zero_s, inv_s, sck_s, si_s, loc_s, tilt_s,
          ledr_s, temp_s, lowl_s, sin_s, cos_s} = sync2_q;

  // ---------------- position path ----------------
  logic [POS_BITS-1:0] raw_pos_q;
  logic [POS_BITS-1:0] zero_ref_q;
  logic [POS_BITS-1:0] rel_pos;
  logic [POS_BITS-1:0] rep_pos;
  logic                zero_prev_q;

  // coarse and fine bits are latched together so they stay aligned
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      raw_pos_q <= '0;
    end else begin
      raw_pos_q <= coarse_fine_s;
    end
  end

  // falling preset captures the current position as zero; lost at power loss
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      zero_ref_q  <= '0;
      zero_prev_q <= 1'b1;
    end else begin
      zero_prev_q <= zero_s;
      if (zero_prev_q && !zero_s) begin
        zero_ref_q <= raw_pos_q;
      end
    end
  end

  assign rel_pos = raw_pos_q - zero_ref_q;
  assign rep_pos = inv_s ? POS_BITS'(-rel_pos) : rel_pos;

  // ---------------- sampler and buffer ----------------
  logic [POS_BITS-1:0] samp_q;
  logic                samp_valid_q;
  logic                buf_in_ready;
  logic                buf_out_valid;
  logic [POS_BITS-1:0] buf_out_data;
  logic                buf_out_ready;

  // sample held until the buffer takes it, so back pressure stalls sampling
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      samp_q       <= '0;
      samp_valid_q <= 1'b0;
    end else if (!samp_valid_q || buf_in_ready) begin
      samp_q       <= rep_pos;
      samp_valid_q <= 1'b1;
    end
  end

  aenc_pair_buf #(
    .WIDTH (POS_BITS),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk       (sys_clk),
    .rst       (rst),
    .in_valid  (samp_valid_q),
    .in_data   (samp_q),
    .in_ready  (buf_in_ready),
    .out_valid (buf_out_valid),
    .out_data  (buf_out_data),
    .out_ready (buf_out_ready)
  );

  // ---------------- word handshake into link domain ----------------
  logic [POS_BITS-1:0] xfer_word_q;
  logic                req_q;
  logic                ack_s1_q;
  logic                ack_s2_q;
  logic                ack_l_q;
  logic [5:0]          lrst_cnt_q;
  logic                link_rst_q;

  // words wait until the link reset request has ended, else the link ack is unknown
  assign buf_out_ready = !link_rst_q && (ack_s2_q == req_q);

  // link reset request stretched so that a few readout clocks catch it;
  // a host that gives no clocks in that time leaves the link unreset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lrst_cnt_q <= 6'h3f;
      link_rst_q <= 1'b1;
    end else begin
      if (lrst_cnt_q != 6'h00) begin
        lrst_cnt_q <= lrst_cnt_q - 6'h01;
      end
      link_rst_q <= (lrst_cnt_q != 6'h00);
    end
  end

  // word stays stable from request toggle until the ack returns
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      xfer_word_q <= '0;
      req_q       <= 1'b0;
      ack_s1_q    <= 1'b0;
      ack_s2_q    <= 1'b0;
    end else begin
      ack_s1_q <= ack_l_q;
      ack_s2_q <= ack_s1_q;
      if (buf_out_valid && buf_out_ready) begin
        xfer_word_q <= buf_out_data;
        req_q       <= ~req_q;
      end
    end
  end

  // ---------------- link domain, falling edge of readout clock ----------------
  logic                rst_l1_q;
  logic                rst_l2_q;
  logic                req_l1_q;
  logic                req_l2_q;
  logic [POS_BITS-1:0] link_word_q;
  logic [POS_BITS-1:0] shift_q;
  logic [4:0]          bit_cnt_q;
  logic                frame_load;

  // select and clock both come from the host, so select is sampled directly
  assign frame_load = !readout_select_n &&
                      (bit_cnt_q == 5'd0 || bit_cnt_q == `AENC_FRAME_WRAP);

  // local reset and request synchronisers
  always_ff @(negedge readout_clk) begin
    rst_l1_q <= link_rst_q;
    rst_l2_q <= rst_l1_q;
    req_l1_q <= req_q;
    req_l2_q <= req_l1_q;
  end

  // new words are accepted only between frames so a frame never tears
  always_ff @(negedge readout_clk) begin
    if (rst_l2_q) begin
      link_word_q <= '0;
      ack_l_q     <= 1'b0;
    end else if (req_l2_q != ack_l_q && !frame_load && bit_cnt_q == 5'd0) begin
      link_word_q <= xfer_word_q;
      ack_l_q     <= req_l2_q;
    end
  end

  // data changes on the falling edge, stable through the low phase
  always_ff @(negedge readout_clk) begin
    if (rst_l2_q || readout_select_n) begin
      bit_cnt_q    <= 5'd0;
      shift_q      <= '0;
      pos_data_out <= 1'b1;
    end else if (frame_load) begin
      shift_q      <= {link_word_q[POS_BITS-2:0], 1'b0};
      pos_data_out <= link_word_q[POS_BITS-1];
      bit_cnt_q    <= 5'd1;
    end else begin
      shift_q      <= {shift_q[POS_BITS-2:0], 1'b0};
      pos_data_out <= (bit_cnt_q < `AENC_FRAME_BITS) ? shift_q[POS_BITS-1] : 1'b0;
      bit_cnt_q    <= bit_cnt_q + 5'd1;
    end
  end

  msb_first_a: assert property (@(negedge readout_clk) disable iff (rst_l2_q)
    frame_load |=> pos_data_out == $past(link_word_q[POS_BITS-1]))
    else $error("first readout bit is not the top bit");
  select_gate_a: assert property (@(negedge readout_clk) disable iff (rst_l2_q)
    readout_select_n |=> bit_cnt_q == 5'd0 && pos_data_out)
    else $error("readout advanced while select high");
  frame_length_a: assert property (@(negedge readout_clk) disable iff (rst_l2_q)
    !readout_select_n ##1 !readout_select_n |->
    bit_cnt_q == (($past(bit_cnt_q) == `AENC_FRAME_WRAP) ? 5'd1 : $past(bit_cnt_q) + 5'd1))
    else $error("frame did not count one bit per clock");

  // ---------------- configuration port ----------------
  aenc_pkg::aenc_spi_state_t spi_st_q;
  logic       sck_prev_q;
  logic [4:0] spi_cnt_q;
  logic [15:0] spi_sr_q;
  logic [7:0] rd_sr_q;
  logic [7:0] idle_q;
  logic [7:0] mode_q;
  logic       unlock_q;
  logic       access_q;
  logic       sck_rise;
  logic       sck_fall;
  logic       align;

  assign sck_rise = sck_s && !sck_prev_q;
  assign sck_fall = !sck_s && sck_prev_q;
  assign align    = (mode_q == `AENC_MODE_ALIGN);

  // true when a finished frame is a write to the given address
  function automatic logic wr_hit(input logic [15:0] fr, input logic [5:0] adr);
    wr_hit = (fr[15:14] == `AENC_CMD_WRITE) && (fr[13:8] == adr);
  endfunction

  // frame sequencer; a quiet clock line ends a stray partial frame
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      spi_st_q   <= aenc_pkg::AENC_SPI_IDLE;
      sck_prev_q <= 1'b0;
      spi_cnt_q  <= 5'd0;
      spi_sr_q   <= 16'h0000;
      idle_q     <= 8'h00;
    end else begin
      sck_prev_q <= sck_s;
      idle_q     <= (sck_rise || sck_fall) ? 8'h00 : idle_q + 8'h01;
      case (spi_st_q)
        aenc_pkg::AENC_SPI_IDLE: begin
          spi_cnt_q <= 5'd0;
          if (sck_rise) begin
            spi_sr_q  <= {spi_sr_q[14:0], si_s};
            spi_cnt_q <= 5'd1;
            spi_st_q  <= aenc_pkg::AENC_SPI_SHIFT;
          end
        end
        aenc_pkg::AENC_SPI_SHIFT: begin
          if (sck_rise) begin
            spi_sr_q  <= {spi_sr_q[14:0], si_s};
            spi_cnt_q <= spi_cnt_q + 5'd1;
            if (spi_cnt_q == `AENC_SPI_BITS - 5'd1) begin
              spi_st_q <= aenc_pkg::AENC_SPI_EXEC;
            end
          end else if (idle_q == 8'(SPI_IDLE)) begin
            spi_st_q <= aenc_pkg::AENC_SPI_IDLE;
          end
        end
        default: begin
          spi_st_q <= aenc_pkg::AENC_SPI_IDLE;
        end
      endcase
    end
  end

  // register writes take effect in the exec cycle after the 16th bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_q   <= `AENC_MODE_RESET;
      unlock_q <= 1'b0;
      access_q <= 1'b0;
    end else if (spi_st_q == aenc_pkg::AENC_SPI_EXEC) begin
      if (wr_hit(spi_sr_q, `AENC_REG_ACCESS) && spi_sr_q[7:0] == `AENC_KEY_ACCESS) begin
        access_q <= 1'b1;
      end
      if (wr_hit(spi_sr_q, `AENC_REG_UNLOCK) && access_q &&
          spi_sr_q[7:0] == `AENC_KEY_UNLOCK) begin
        unlock_q <= 1'b1;
      end
      if (wr_hit(spi_sr_q, `AENC_REG_MODE) && spi_sr_q[7:0] == `AENC_MODE_RESET) begin
        mode_q   <= `AENC_MODE_RESET;
        unlock_q <= 1'b0;
      end else if (wr_hit(spi_sr_q, `AENC_REG_MODE) && unlock_q) begin
        mode_q <= spi_sr_q[7:0];
      end
    end
  end

  // read data shifts out on falling clock during the data byte
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_sr_q <= 8'h00;
      spi_so  <= 1'b0;
    end else if (sck_fall && spi_st_q == aenc_pkg::AENC_SPI_SHIFT) begin
      if (spi_cnt_q == `AENC_SPI_DATA_START) begin
        // only the mode register reads back; key registers are write only
        rd_sr_q <= {mode_q[6:0], 1'b0};
        spi_so  <= (spi_sr_q[7:6] == `AENC_CMD_READ && spi_sr_q[5:0] == `AENC_REG_MODE)
                   ? mode_q[7] : 1'b0;
        if (!(spi_sr_q[7:6] == `AENC_CMD_READ && spi_sr_q[5:0] == `AENC_REG_MODE)) begin
          rd_sr_q <= 8'h00;
        end
      end else begin
        rd_sr_q <= {rd_sr_q[6:0], 1'b0};
        spi_so  <= rd_sr_q[7];
      end
    end else if (spi_st_q == aenc_pkg::AENC_SPI_IDLE) begin
      spi_so <= 1'b0;
    end
  end

  // ---------------- status, alignment and quadrature outputs ----------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fault_flag_out  <= 1'b0;
      locate_test_out <= 1'b0;
      tilt_out        <= 1'b0;
      quad_channel_a  <= 1'b0;
      quad_channel_b  <= 1'b0;
    end else begin
      fault_flag_out  <= ledr_s || temp_s || lowl_s;
      locate_test_out <= align && loc_s;
      tilt_out        <= align && tilt_s;
      quad_channel_a  <= sin_s;
      quad_channel_b  <= cos_s;
    end
  end

  coarse_fine_a: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 raw_pos_q == $past(coarse_fine_s)) else $error("position not track plus fine");
  invert_dir_a: assert property (@(posedge sys_clk) disable iff (rst)
    inv_s |-> rep_pos + raw_pos_q - zero_ref_q == '0) else $error("inverted count wrong");
  zero_capture_a: assert property (@(posedge sys_clk) disable iff (rst)
    (zero_prev_q && !zero_s) |=> zero_ref_q == $past(raw_pos_q) && rel_pos == '0 ||
    raw_pos_q != $past(raw_pos_q)) else $error("zero preset not captured");
  unlock_key_a: assert property (@(posedge sys_clk) disable iff (rst)
    (spi_st_q == aenc_pkg::AENC_SPI_EXEC && access_q && wr_hit(spi_sr_q, `AENC_REG_UNLOCK)
     && spi_sr_q[7:0] == `AENC_KEY_UNLOCK) |=> unlock_q) else $error("unlock ignored");
  align_enter_a: assert property (@(posedge sys_clk) disable iff (rst)
    (spi_st_q == aenc_pkg::AENC_SPI_EXEC && unlock_q && wr_hit(spi_sr_q, `AENC_REG_MODE)
     && spi_sr_q[7:0] == `AENC_MODE_ALIGN) |=> align ##2 tilt_out == $past(tilt_s, 1))
    else $error("alignment mode not entered");
  align_leave_a: assert property (@(posedge sys_clk) disable iff (rst)
    (spi_st_q == aenc_pkg::AENC_SPI_EXEC && wr_hit(spi_sr_q, `AENC_REG_MODE)
     && spi_sr_q[7:0] == `AENC_MODE_RESET) |=> !align ##1 !locate_test_out)
    else $error("alignment mode not left");
  locate_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 locate_test_out == ($past(align) && $past(loc_s))) else $error("locate routing wrong");
  fault_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
    (ledr_s || temp_s || lowl_s) |=> fault_flag_out) else $error("fault not raised");
endmodule
`default_nettype wire

// File: testbench/aenc_host_model.sv
// host controller model: serial position reader and configuration writer
`default_nettype none
module aenc_host_model #(
  parameter int RD_HALF  = 80,
  parameter int SPI_HALF = 1000
) (
  // readout link
  output logic        readout_clk,
  output logic        readout_select_n,
  input  wire logic   pos_data_out,
  // configuration port
  output logic        spi_clk,
  output logic        spi_si,
  input  wire logic   spi_so,
  // results handed to the bench
  output logic [16:0] word,
  output logic        word_done
);
  timeunit 1ns;
  timeprecision 1ps;

  // select high from before power-on; the link clock parks high between frames
  initial begin
    readout_select_n = 1'b1;
    readout_clk = 1'b1;
    spi_clk = 1'b0;
    spi_si = 1'b0;
    word = 17'h00000;
    word_done = 1'b0;
  end

  // one readout clock, data taken mid low phase where the device holds it
  task automatic rd_cycle(input int half, output logic b);
    #(half) readout_clk = 1'b0;
    #(half / 2) b = pos_data_out;
    #(half - half / 2) readout_clk = 1'b1;
  endtask

  // clocks with select high, so the link side sees reset and fresh words
  task automatic idle_clocks(input int n);
    logic b;
    for (int i = 0; i < n; i++) rd_cycle(RD_HALF, b);
  endtask

  // frames back to back; select stays low between them, as in two-wire use
  task automatic read_frames(input int n, input int half);
    logic b;
    readout_select_n = 1'b0;
    for (int f = 0; f < n; f++) begin
      for (int i = 0; i < 17; i++) begin
        rd_cycle(half, b);
        word = {word[15:0], b};
      end
      word_done = 1'b1;
      rd_cycle(half, b); // trailing low bit before the next frame
      word_done = 1'b0;
    end
    #(half) readout_select_n = 1'b1;
  endtask

  // 16-bit frame, data set while clock low; read data taken on rises 9..16
  task automatic spi_frame(input logic [1:0] cmd, input logic [5:0] addr,
                           input logic [7:0] data);
    logic [15:0] f;
    logic [7:0]  rd;
    f = {cmd, addr, data};
    rd = 8'h00;
    for (int i = 0; i < 16; i++) begin
      spi_si = f[15 - i];
      #(SPI_HALF) spi_clk = 1'b1;
      if (i >= 8) rd = {rd[6:0], spi_so};
      #(SPI_HALF) spi_clk = 1'b0;
    end
    spi_si = ~spi_si; // no stale level once released
    #(SPI_HALF);
    if (cmd == 2'b10) begin
      word = {9'h000, rd};
      word_done = 1'b1;
      #(SPI_HALF) word_done = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// self-checking bench for the absolute encoder readout block
`include "aenc_defines.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // stimulus and observed signals
  logic        sys_clk, rst, chk_stat;
  logic [12:0] track_bits;
  logic [3:0]  fine_bits;
  logic        sine_sign, cosine_sign, radial_locate_sensor, tilt_detect;
  logic        led_range_err, temp_over_limit, light_low;
  logic        zero_preset_n, count_direction_invert;
  logic        readout_clk, readout_select_n, pos_data_out, spi_clk, spi_si, spi_so;
  logic        fault_flag_out, locate_test_out, tilt_out, quad_channel_a, quad_channel_b;
  logic [16:0] word, zero_ref;
  logic        word_done;
  logic [16:0] exp_q[$];
  logic [4:0]  stat_q[$];
  int          n_mismatch, total_checks, seed;

  initial begin
    {sys_clk, chk_stat, track_bits, fine_bits, sine_sign, cosine_sign} = '0;
    {radial_locate_sensor, tilt_detect, led_range_err, temp_over_limit} = '0;
    {light_low, count_direction_invert} = '0;
    zero_preset_n = 1'b1;
    rst = 1'b1;
    zero_ref = 17'h00000;
    n_mismatch = 0;
    total_checks = 0;
    seed = 32'had6b;
  end

  always #12.5 sys_clk = ~sys_clk;

  aenc_readout #(.POS_BITS(17), .BUF_DEPTH(2), .SPI_IDLE(200)) aenc_readout_i (
    .sys_clk(sys_clk), .rst(rst), .readout_clk(readout_clk),
    .readout_select_n(readout_select_n), .pos_data_out(pos_data_out),
    .track_bits(track_bits), .fine_bits(fine_bits), .sine_sign(sine_sign),
    .cosine_sign(cosine_sign), .radial_locate_sensor(radial_locate_sensor),
    .tilt_detect(tilt_detect), .led_range_err(led_range_err),
    .temp_over_limit(temp_over_limit), .light_low(light_low),
    .zero_preset_n(zero_preset_n), .count_direction_invert(count_direction_invert),
    .spi_clk(spi_clk), .spi_si(spi_si), .spi_so(spi_so),
    .fault_flag_out(fault_flag_out), .locate_test_out(locate_test_out),
    .tilt_out(tilt_out), .quad_channel_a(quad_channel_a), .quad_channel_b(quad_channel_b));

  aenc_host_model #(.RD_HALF(80), .SPI_HALF(1000)) aenc_host_model_i (
    .readout_clk(readout_clk), .readout_select_n(readout_select_n),
    .pos_data_out(pos_data_out), .spi_clk(spi_clk), .spi_si(spi_si),
    .spi_so(spi_so), .word(word), .word_done(word_done));

  task automatic check(input logic [16:0] got, input logic [16:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // frames and register reads against the oldest note
  always @(posedge word_done) begin
    if (exp_q.size() == 0) check(word, 17'h1ffff ^ word, "unexpected word");
    else check(word, exp_q.pop_front(), "serial word");
  end

  // status pins against the oldest note when the driver asks
  always @(posedge sys_clk) begin
    if (chk_stat === 1'b1)
      check({12'h000, fault_flag_out, locate_test_out, tilt_out, quad_channel_a,
             quad_channel_b}, {12'h000, stat_q.pop_front()}, "status pins");
  end

  task automatic report_and_stop();
    if (exp_q.size() != 0) begin
      n_mismatch++;
      $display("[FAIL] %0t expected results never appeared", $time);
    end
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // status pins settle three cycles after a pin change; six gives margin
  task automatic stat(input logic [4:0] e);
    cyc(6);
    stat_q.push_back(e);
    chk_stat <= 1'b1;
    cyc(1);
    chk_stat <= 1'b0;
  endtask

  task automatic spi_wr(input logic [5:0] a, input logic [7:0] d);
    aenc_host_model_i.spi_frame(`AENC_CMD_WRITE, a, d);
  endtask

  task automatic spi_rd(input logic [7:0] e);
    exp_q.push_back({9'h000, e});
    aenc_host_model_i.spi_frame(`AENC_CMD_READ, `AENC_REG_MODE, 8'h00);
  endtask

  function automatic logic [16:0] exp_pos(input logic [16:0] p, input logic inv);
    logic [16:0] d;
    d = p - zero_ref;
    exp_pos = inv ? (17'h00000 - d) : d;
  endfunction

  // new random position, let it cross, then read whole frames
  task automatic read_pos(input int frames, input int half);
    logic [16:0] p;
    p = 17'($random(seed));
    @(posedge sys_clk);
    track_bits <= p[16:4];
    fine_bits <= p[3:0];
    cyc(8);
    // buffer, sampler and handshake hold up to five older words; flush them
    aenc_host_model_i.idle_clocks(24);
    repeat (frames) exp_q.push_back(exp_pos(p, count_direction_invert));
    aenc_host_model_i.read_frames(frames, half);
  endtask

  initial begin
    #1000000;
    n_mismatch++;
    $display("[FAIL] %0t run did not finish in time", $time);
    report_and_stop();
  end

  initial begin
    logic [1:0] r;
    cyc(4);
    rst <= 1'b0;
    aenc_host_model_i.idle_clocks(8);
    stat(5'h00);
    for (int i = 0; i < 4; i++) begin
      r = 2'($random(seed));
      {sine_sign, cosine_sign} <= r;
      stat({3'b000, r});
    end
    {sine_sign, cosine_sign} <= 2'b00;
    for (int i = 0; i < 3; i++) begin
      {led_range_err, temp_over_limit, light_low} <= (3'b100 >> i) | 3'($random(seed));
      stat(5'h10);
    end
    {led_range_err, temp_over_limit, light_low} <= 3'b000;
    stat(5'h00);
    read_pos(1, 80);
    count_direction_invert <= 1'b1;
    cyc(2);
    read_pos(1, 80);
    count_direction_invert <= 1'b0;
    zero_preset_n <= 1'b0;
    cyc(6);
    zero_preset_n <= 1'b1;
    zero_ref = {track_bits, fine_bits};
    read_pos(1, 80);
    read_pos(2, 340);
    radial_locate_sensor <= 1'b1;
    tilt_detect <= 1'b1;
    spi_wr(`AENC_REG_UNLOCK, `AENC_KEY_UNLOCK);
    spi_wr(`AENC_REG_MODE, `AENC_MODE_ALIGN);
    stat(5'h00);
    spi_rd(`AENC_MODE_RESET);
    spi_wr(`AENC_REG_ACCESS, `AENC_KEY_ACCESS);
    spi_wr(`AENC_REG_UNLOCK, `AENC_KEY_UNLOCK);
    spi_wr(`AENC_REG_MODE, `AENC_MODE_ALIGN);
    stat(5'h0c);
    spi_rd(`AENC_MODE_ALIGN);
    for (int i = 0; i < 4; i++) begin
      r = 2'($random(seed));
      {radial_locate_sensor, tilt_detect} <= r;
      stat({1'b0, r, 2'b00});
    end
    spi_wr(`AENC_REG_MODE, `AENC_MODE_RESET);
    stat(5'h00);
    spi_rd(`AENC_MODE_RESET);
    cyc(10);
    report_and_stop();
  end
endmodule
`default_nettype wire
